// file: common/flc_defines.vh
// constants for the flexible line configuration block: register addresses,
// line numbering, reset values and access timing.
// assumes word-addressed register space with 16-bit register addresses.
`ifndef FLC_DEFINES_VH
`define FLC_DEFINES_VH

// ----------------------------------------------------------------------------
// register start addresses
// ----------------------------------------------------------------------------
`define FLC_ADDR_ANALOG_VOLTAGE_LINE 16'h0008
`define FLC_ADDR_SINGLE_LINE_DIGITAL 16'h07D4
`define FLC_ADDR_BULK_LINE_LEVELS    16'h0AF0
`define FLC_ADDR_BULK_LINE_DIRECTION 16'h0B22
`define FLC_ADDR_BULK_ANALOG_SELECT  16'h0B40
`define FLC_ADDR_PULLUP_OFF_MASK     16'h0B4A
`define FLC_ADDR_WRITE_BLOCK_MASK    16'h0B54

// ----------------------------------------------------------------------------
// line numbering and register spacing
// ----------------------------------------------------------------------------
`define FLC_NUM_LINES       8
`define FLC_FIRST_LINE      4
`define FLC_ANALOG_STRIDE   2
`define FLC_MASK_WIDTH      32
`define FLC_DIGITAL_WIDTH   16

// ----------------------------------------------------------------------------
// reset values (all lines digital input, pull-ups on, nothing blocked)
// ----------------------------------------------------------------------------
`define FLC_RST_ANALOG_SEL  8'h00
`define FLC_RST_DIRECTION   8'h00
`define FLC_RST_LEVELS      8'h00
`define FLC_RST_PULLUP_OFF  8'h00
`define FLC_RST_BLOCK_MASK  8'h00

// ----------------------------------------------------------------------------
// access timing in sys_clk cycles
// ----------------------------------------------------------------------------
`define FLC_READ_LATENCY    2
`define FLC_WRITE_LATENCY   2

`endif

// file: design/flc_sample_mem.v
// small sample store for the latest converted voltage of each line.
// assumes one writer (the converter) and one reader; read data are registered.
`timescale 1ns/10ps
`default_nettype none

module flc_sample_mem #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             sys_clk,
    input  wire             rst,
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_addr,
    input  wire [WIDTH-1:0] wr_data,
    input  wire [AW-1:0]    rd_addr,
    output reg  [WIDTH-1:0] rd_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    // array has no reset so it can map to a small ram
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read port; a write to the same slot shows up one cycle later
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data <= {WIDTH{1'b0}};
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

`default_nettype wire

// file: design/flc_line_ctrl.v
// configuration and access logic for eight flexible lines, numbered 4 to 11.
// assumes pad inputs are already synchronous to sys_clk and a converter
// elsewhere delivers voltage samples on the sample write port.
`timescale 1ns/10ps
`default_nettype none
`include "flc_defines.vh"

// Notes on behaviour
// [R1] eight lines numbered 4 to 11 each act as analog input, digital input or digital output.
// [R2] the single-line digital register reads and writes 0 as low and 1 as high and sets direction.
// [R3] reading a single-line digital register makes the line a digital input, then returns its sampled level.
// [R4] writing a single-line digital register makes it an output unless the line is analog, where the write is dropped.
// [R5] reading a line's analog register switches it to analog and returns a 32-bit float voltage.
// [R6] an inhibit mask bit of 1 blocks bulk level, direction and analog-select writes to that line.
// [R7] the bulk analog-select mask uses 1 for analog and 0 for digital, filtered by the inhibit mask.
// [R8] a line leaving analog mode through the bulk analog-select mask becomes a digital input.
// [R9] the bulk direction mask uses 0 for input and 1 for output and is filtered by the inhibit mask.
// [R10] bulk level writes set output levels, are filtered by the inhibit mask and leave direction alone.
// [R11] a bulk level read returns the sampled pad level of each line, even for outputs.
// [R12] in every bulk mask the bit position equals the line number.
// [R13] the pull-up off mask disables with 1, acts on digital inputs only and is not filtered by inhibit.
// [R14] software clears inhibit, analog and direction bits before writing a line as output.
// [R15] software clears inhibit, sets analog select and then reads the analog register.
// [R16] software forces an analog line to output by a digital read then a write, minding external sources.
// [R17] mask bits for lines that do not exist read as zero and writes to them do nothing.
module flc_line_ctrl #(
    parameter NUM_LINES  = `FLC_NUM_LINES,
    parameter FIRST_LINE = `FLC_FIRST_LINE,
    parameter SAMPLE_W   = 32
) (
    input  wire                 sys_clk,
    input  wire                 rst,
    // register access port
    input  wire [15:0]          reg_addr,
    input  wire                 reg_rd,
    input  wire                 reg_wr,
    input  wire [31:0]          reg_wdata,
    output reg  [31:0]          reg_rdata,
    output reg                  reg_ack,
    output wire                 reg_busy,
    // converter sample write port
    input  wire                 sample_wr,
    input  wire [2:0]           sample_line,
    input  wire [SAMPLE_W-1:0]  sample_data,
    // pads, bit 0 is line FIRST_LINE
    input  wire [NUM_LINES-1:0] pad_in,
    output reg  [NUM_LINES-1:0] pad_out,
    output reg  [NUM_LINES-1:0] pad_oe,
    output reg  [NUM_LINES-1:0] pad_pullup_en,
    output reg  [NUM_LINES-1:0] pad_analog_sel
);

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------
    // place per-line bits at their line-number positions; other bits stay zero
    function [31:0] to_mask;
        input [NUM_LINES-1:0] lines;
        begin
            to_mask = {{(32-NUM_LINES-FIRST_LINE){1'b0}}, lines, {FIRST_LINE{1'b0}}}; // [R12] [R17]
        end
    endfunction

    // pick the per-line bits out of a mask; bits of absent lines are dropped
    function [NUM_LINES-1:0] from_mask;
        input [31:0] mask;
        begin
            from_mask = mask[FIRST_LINE +: NUM_LINES]; // [R12] [R17]
        end
    endfunction

    // one-hot select of a line index
    function [NUM_LINES-1:0] one_hot;
        input [2:0] idx;
        begin
            one_hot = {{(NUM_LINES-1){1'b0}}, 1'b1} << idx;
        end
    endfunction

    // bulk write merge: blocked lines keep their old bit, open lines take the new one
    function [NUM_LINES-1:0] merge_masked;
        input [NUM_LINES-1:0] old_bits;
        input [NUM_LINES-1:0] new_bits;
        input [NUM_LINES-1:0] open_bits;
        begin
            merge_masked = (old_bits & ~open_bits) | (new_bits & open_bits); // [R6]
        end
    endfunction

    // true when an address falls inside a register window that starts at base
    function in_window;
        input [15:0] addr;
        input [15:0] base;
        input [15:0] span;
        begin
            in_window = (addr >= base) && ((addr - base) < span);
        end
    endfunction

    // ------------------------------------------------------------------------
    // access kinds
    // ------------------------------------------------------------------------
    localparam [2:0] K_NONE    = 3'd0;
    localparam [2:0] K_DIGITAL = 3'd1;
    localparam [2:0] K_ANALOG  = 3'd2;
    localparam [2:0] K_LEVELS  = 3'd3;
    localparam [2:0] K_DIR     = 3'd4;
    localparam [2:0] K_ASEL    = 3'd5;
    localparam [2:0] K_PULLUP  = 3'd6;
    localparam [2:0] K_BLOCK   = 3'd7;

    localparam [15:0] ANALOG_SPAN  = NUM_LINES * `FLC_ANALOG_STRIDE;
    localparam [15:0] DIGITAL_SPAN = NUM_LINES;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    reg [NUM_LINES-1:0] analog_q;
    reg [NUM_LINES-1:0] dir_q;
    reg [NUM_LINES-1:0] level_q;
    reg [NUM_LINES-1:0] pullup_off_q;
    reg [NUM_LINES-1:0] block_q;
    reg                 pend_q;
    reg                 pend_rd_q;
    reg [2:0]           pend_kind_q;
    reg [2:0]           pend_idx_q;

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    wire [15:0] ain_off = reg_addr - `FLC_ADDR_ANALOG_VOLTAGE_LINE;
    wire [15:0] dig_off = reg_addr - `FLC_ADDR_SINGLE_LINE_DIGITAL;
    reg  [2:0]  kind;
    reg  [2:0]  idx;

    // each analog register spans two words; only its start address answers
    always @* begin
        kind = K_NONE;
        idx  = 3'd0;
        if (in_window(reg_addr, `FLC_ADDR_ANALOG_VOLTAGE_LINE, ANALOG_SPAN) && !ain_off[0]) begin
            kind = K_ANALOG;
            idx  = ain_off[3:1];
        end else if (in_window(reg_addr, `FLC_ADDR_SINGLE_LINE_DIGITAL, DIGITAL_SPAN)) begin
            kind = K_DIGITAL;
            idx  = dig_off[2:0];
        end else begin
            case (reg_addr)
                `FLC_ADDR_BULK_LINE_LEVELS:    kind = K_LEVELS;
                `FLC_ADDR_BULK_LINE_DIRECTION: kind = K_DIR;
                `FLC_ADDR_BULK_ANALOG_SELECT:  kind = K_ASEL;
                `FLC_ADDR_PULLUP_OFF_MASK:     kind = K_PULLUP;
                `FLC_ADDR_WRITE_BLOCK_MASK:    kind = K_BLOCK;
                default:                       kind = K_NONE;
            endcase
        end
    end

    // one access at a time; a request while busy is ignored
    // busy spans the pending and answer cycles, so accesses are three cycles apart
    assign reg_busy = pend_q | reg_ack;
    wire   take_rd  = reg_rd & ~reg_busy;
    wire   take_wr  = reg_wr & ~reg_rd & ~reg_busy;

    // ------------------------------------------------------------------------
    // line configuration updates
    // ------------------------------------------------------------------------
    wire [NUM_LINES-1:0] sel     = one_hot(idx);
    wire [NUM_LINES-1:0] wmask   = from_mask(reg_wdata);
    wire [NUM_LINES-1:0] allowed = ~block_q; // [R6]
    reg  [NUM_LINES-1:0] analog_d;
    reg  [NUM_LINES-1:0] dir_d;
    reg  [NUM_LINES-1:0] level_d;
    reg  [NUM_LINES-1:0] pullup_off_d;
    reg  [NUM_LINES-1:0] block_d;
    reg  [NUM_LINES-1:0] leaving;

    // side effects of reads and writes land at the edge that takes the request
    always @* begin
        analog_d     = analog_q;
        dir_d        = dir_q;
        level_d      = level_q;
        pullup_off_d = pullup_off_q;
        block_d      = block_q;
        leaving      = {NUM_LINES{1'b0}};
        if (take_rd) begin
            case (kind)
                K_DIGITAL: begin
                    analog_d = analog_q & ~sel; // [R3]
                    dir_d    = dir_q & ~sel;    // [R3]
                end
                K_ANALOG: begin
                    analog_d = analog_q | sel;  // [R5]
                end
                default: begin
                    analog_d = analog_q;
                end
            endcase
        end else if (take_wr) begin
            case (kind)
                K_DIGITAL: begin
                    // an analog line keeps its mode and the write is dropped
                    if ((analog_q & sel) == {NUM_LINES{1'b0}}) begin // [R4]
                        dir_d   = dir_q | sel;                       // [R2]
                        level_d = reg_wdata[0] ? (level_q | sel) : (level_q & ~sel); // [R2]
                    end
                end
                K_LEVELS: begin
                    level_d = merge_masked(level_q, wmask, allowed); // [R10]
                end
                K_DIR: begin
                    dir_d = merge_masked(dir_q, wmask, allowed); // [R9]
                end
                K_ASEL: begin
                    analog_d = merge_masked(analog_q, wmask, allowed); // [R7]
                    // a line leaving analog falls back to input even if its direction bit was set
                    leaving  = analog_q & ~wmask & allowed;
                    dir_d    = dir_q & ~leaving; // [R8]
                end
                K_PULLUP: begin
                    pullup_off_d = wmask; // [R13]
                end
                K_BLOCK: begin
                    block_d = wmask; // [R6]
                end
                default: begin
                    block_d = block_q;
                end
            endcase
        end
    end

    // configuration registers; reset leaves every line a digital input
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            analog_q     <= `FLC_RST_ANALOG_SEL;
            dir_q        <= `FLC_RST_DIRECTION;
            level_q      <= `FLC_RST_LEVELS;
            pullup_off_q <= `FLC_RST_PULLUP_OFF;
            block_q      <= `FLC_RST_BLOCK_MASK;
        end else begin
            analog_q     <= analog_d;
            dir_q        <= dir_d;
            level_q      <= level_d;
            pullup_off_q <= pullup_off_d;
            block_q      <= block_d;
        end
    end

    // ------------------------------------------------------------------------
    // pad drive
    // ------------------------------------------------------------------------
    // next pad values follow the configuration as it stands after this edge
    wire [NUM_LINES-1:0] pad_oe_d     = dir_d & ~analog_d;                  // [R1]
    wire [NUM_LINES-1:0] pad_pullup_d = ~pullup_off_d & ~dir_d & ~analog_d; // [R13]

    // analog mode wins over a stale output direction so no driver fights the source
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pad_out        <= {NUM_LINES{1'b0}};
            pad_oe         <= {NUM_LINES{1'b0}};
            pad_pullup_en  <= {NUM_LINES{1'b0}};
            pad_analog_sel <= {NUM_LINES{1'b0}};
        end else begin
            pad_out        <= level_d;
            pad_oe         <= pad_oe_d;
            pad_pullup_en  <= pad_pullup_d;
            pad_analog_sel <= analog_d;                          // [R1]
        end
    end

    // ------------------------------------------------------------------------
    // sample store
    // ------------------------------------------------------------------------
    // read address is the decoded index, so the sample stands one edge after the take
    wire [SAMPLE_W-1:0] sample_rd;

    flc_sample_mem #(
        .WIDTH (SAMPLE_W),
        .DEPTH (NUM_LINES),
        .AW    (3)
    ) u_sample_mem (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (sample_wr),
        .wr_addr (sample_line),
        .wr_data (sample_data),
        .rd_addr (idx),
        .rd_data (sample_rd)
    );

    // ------------------------------------------------------------------------
    // answer pipeline
    // ------------------------------------------------------------------------
    // two stages so the analog read can use the registered sample output
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend_q      <= 1'b0;
            pend_rd_q   <= 1'b0;
            pend_kind_q <= K_NONE;
            pend_idx_q  <= 3'd0;
        end else begin
            pend_q      <= take_rd | take_wr;
            pend_rd_q   <= take_rd;
            pend_kind_q <= kind;
            pend_idx_q  <= idx;
        end
    end

    reg [31:0] rdata_d;

    // read mux for the access taken one edge ago, so a digital read sees the
    // pad after it became an input; unmapped reads and all writes give zero
    always @* begin
        rdata_d = 32'h0000_0000;
        if (pend_q && pend_rd_q) begin
            case (pend_kind_q)
                K_DIGITAL: rdata_d = {31'h0000_0000, pad_in[pend_idx_q]}; // [R3]
                K_ANALOG:  rdata_d = sample_rd;                           // [R5]
                K_LEVELS:  rdata_d = to_mask(pad_in);                     // [R11]
                K_DIR:     rdata_d = to_mask(dir_q);                      // [R9]
                K_ASEL:    rdata_d = to_mask(analog_q);                   // [R7]
                K_PULLUP:  rdata_d = to_mask(pullup_off_q);               // [R13]
                K_BLOCK:   rdata_d = to_mask(block_q);                    // [R6]
                default:   rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // answer registers; read data stand only in the acknowledge cycle
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
            reg_ack   <= 1'b0;
        end else begin
            reg_ack   <= pend_q;
            reg_rdata <= rdata_d;
        end
    end

endmodule

`default_nettype wire

// file: dv/flc_line_ctrl_properties.sv
// checker for the flexible line block: register port timing and pad coherence.
// assumes it is bound to flc_line_ctrl and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module flc_line_ctrl_props #(
    parameter NUM_LINES = 8
) (
    input wire logic                 sys_clk,
    input wire logic                 rst,
    input wire logic                 reg_rd,
    input wire logic                 reg_wr,
    input wire logic [31:0]          reg_rdata,
    input wire logic                 reg_ack,
    input wire logic                 reg_busy,
    input wire logic [NUM_LINES-1:0] pad_out,
    input wire logic [NUM_LINES-1:0] pad_oe,
    input wire logic [NUM_LINES-1:0] pad_pullup_en,
    input wire logic [NUM_LINES-1:0] pad_analog_sel
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // a request counts only while the port is idle
    logic take;
    assign take = (reg_rd || reg_wr) && !reg_busy;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_ack_lat; take |-> ##2 reg_ack; endproperty
    property p_ack_src; reg_ack |-> $past(take, 2); endproperty
    property p_ack_pulse; reg_ack |=> !reg_ack; endproperty
    property p_busy; take |=> reg_busy [*2] ##1 !reg_busy; endproperty
    property p_rdata_idle; !reg_ack |-> reg_rdata == 32'h0000_0000; endproperty
    property p_oe_analog; |pad_analog_sel |-> (pad_oe & pad_analog_sel) == '0; endproperty
    property p_pullup; |pad_pullup_en |-> (pad_pullup_en & (pad_oe | pad_analog_sel)) == '0; endproperty
    // pad drive, enable and analog select only move one edge after a taken request, never on their own
    property p_pads_hold;
        !$past(take) |-> $stable(pad_oe) && $stable(pad_analog_sel) && $stable(pad_out);
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack missing two cycles after request");
    a_ack_src: assert property (p_ack_src) else $error("ack without a taken request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_busy: assert property (p_busy) else $error("busy window wrong");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data nonzero outside ack");
    a_oe_analog: assert property (p_oe_analog) else $error("analog line driven");
    a_pullup: assert property (p_pullup) else $error("pull-up on a non-input line");
    a_pads_hold: assert property (p_pads_hold) else $error("pads changed without request");
    c_read: cover property (take && reg_rd);
    c_refused: cover property (reg_busy && (reg_rd || reg_wr));
    c_analog: cover property ($rose(|pad_analog_sel));
endmodule
bind flc_line_ctrl flc_line_ctrl_props #(.NUM_LINES(NUM_LINES)) u_props (
    .sys_clk(sys_clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_busy(reg_busy), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .pad_analog_sel(pad_analog_sel));
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the flexible line block with an integer model.
// assumes the register port contract: take when idle, ack two cycles later.
`timescale 1ns/10ps
`default_nettype none
`include "flc_defines.vh"
module testbench;
    logic        sys_clk, rst, reg_rd, reg_wr, reg_ack, reg_busy, sample_wr;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, sample_data, rv, seed;
    logic [2:0]  sample_line;
    logic [7:0]  pad_in, pad_out, pad_oe, pad_pullup_en, pad_analog_sel;
    logic [7:0]  m_ana, m_dir, m_lvl, m_puo, m_blk;
    logic [31:0] m_smp [8];
    logic [15:0] atab [5];
    int          n_fail, compares, c, j;

    flc_line_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_busy(reg_busy), .sample_wr(sample_wr), .sample_line(sample_line),
        .sample_data(sample_data), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup_en(pad_pullup_en), .pad_analog_sel(pad_analog_sel));

    // ------------------------------------------------------------------
    // clock, random source, reporting
    // ------------------------------------------------------------------
    // 40 MHz system clock
    initial begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = s[31] ? ({s[30:0], 1'b0} ^ 32'h0040_0007) : {s[30:0], 1'b0};
    endfunction
    task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task end_sim;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // register access; poke tries a refused write while busy
    // ------------------------------------------------------------------
    task acc(input logic rd, input logic [15:0] a, input logic [31:0] d, input logic poke);
        int k;
        reg_rd = rd; reg_wr = !rd; reg_addr = a; reg_wdata = d;
        @(posedge sys_clk); #1;
        reg_rd = 0; reg_wr = poke; reg_addr = `FLC_ADDR_WRITE_BLOCK_MASK; reg_wdata = 32'hFFFF_FFFF;
        for (k = 0; k < 4 && reg_ack !== 1'b1; k++) begin
            @(posedge sys_clk); #1;
        end
        if (reg_ack !== 1'b1) begin
            n_fail++;
            end_sim;
        end
        rv = reg_rdata; reg_wr = 0;
        @(posedge sys_clk); #1;
    endtask

    // one operation on the design and the model, then compare everything
    task op(input int o, input int i, input logic [31:0] d, input logic poke);
        logic [31:0] e;
        logic [7:0]  w, oe;
        w = d[11:4]; e = 0;
        if (o == 2) begin
            sample_wr = 1; sample_line = i[2:0]; sample_data = d; m_smp[i] = d;
            @(posedge sys_clk); #1;
            sample_wr = 0;
        end
        if (o == 0) acc(1, `FLC_ADDR_SINGLE_LINE_DIGITAL + 16'(i), 0, poke);
        else if (o == 1) acc(0, `FLC_ADDR_SINGLE_LINE_DIGITAL + 16'(i), {31'b0, d[0]}, poke);
        else if (o == 2) acc(1, `FLC_ADDR_ANALOG_VOLTAGE_LINE + 16'(2 * i), 0, poke);
        else if (o <= 7) acc(0, atab[o-3], d, poke);
        else if (o <= 12) acc(1, atab[o-8], 0, poke);
        else acc(1, 16'h0009, 0, poke);
        case (o)
            0: begin m_ana[i] = 0; m_dir[i] = 0; e = pad_in[i]; end
            1: if (!m_ana[i]) begin m_dir[i] = 1; m_lvl[i] = d[0]; end
            2: begin m_ana[i] = 1; e = m_smp[i]; end
            3: m_lvl = (m_lvl & m_blk) | (w & ~m_blk);
            4: m_dir = (m_dir & m_blk) | (w & ~m_blk);
            5: begin
                m_dir = m_dir & ~(m_ana & ~w & ~m_blk);
                m_ana = (m_ana & m_blk) | (w & ~m_blk);
            end
            6: m_puo = w;
            7: m_blk = w;
            8: e = {20'h0_0000, pad_in, 4'h0};
            9: e = {20'h0_0000, m_dir, 4'h0};
            10: e = {20'h0_0000, m_ana, 4'h0};
            11: e = {20'h0_0000, m_puo, 4'h0};
            12: e = {20'h0_0000, m_blk, 4'h0};
            default: e = 0;
        endcase
        oe = m_dir & ~m_ana;
        chk("rdata", rv, e);
        chk("pads", {pad_oe, pad_analog_sel, pad_pullup_en, pad_out},
            {oe, m_ana, ~m_puo & ~m_dir & ~m_ana, m_lvl});
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    // reset, reset values, every operation on both end lines, then random traffic
    initial begin
        rst = 1; reg_rd = 0; reg_wr = 0; reg_addr = 0; reg_wdata = 0; sample_wr = 0;
        sample_line = 0; sample_data = 0; pad_in = 8'h00; seed = 32'h18de_c937;
        n_fail = 0; compares = 0;
        atab = '{`FLC_ADDR_BULK_LINE_LEVELS, `FLC_ADDR_BULK_LINE_DIRECTION,
                 `FLC_ADDR_BULK_ANALOG_SELECT, `FLC_ADDR_PULLUP_OFF_MASK, `FLC_ADDR_WRITE_BLOCK_MASK};
        for (c = 0; c < 2; c++) begin
            m_ana = 0; m_dir = 0; m_lvl = 0; m_puo = 0; m_blk = 0;
            repeat (10) @(posedge sys_clk);
            #1 rst = 0;
            for (j = 8; j <= 13; j++) op(j, 0, 0, 0);
            for (j = 0; j < 28; j++) op(j / 2, (j % 2) * 7, 32'hFFFF_FFF1, 0);
            for (j = 0; j < 4; j++) op(j == 0 ? 7 : (j == 3 ? 1 : 6 - j), 0, 1, 0);
            for (j = 0; j < 2; j++) op(5 - 3 * j, 0, 32'h0000_0010, 0);
            for (j = 0; j < 2; j++) op(j, 0, 1, 0);
            for (j = 0; j < 600; j++) begin
                seed = lfsr(seed);
                pad_in = seed[7:0];
                seed = lfsr(seed);
                op(int'(seed[15:8]) % 14, int'(seed[18:16]), lfsr(seed), seed[20] & seed[21]);
            end
            rst = 1;
        end
        end_sim;
    end
endmodule
`default_nettype wire
